// >>> pkg/fbwp_params.svh
`ifndef FBWP_PARAMS_SVH
`define FBWP_PARAMS_SVH
// status byte field positions
`define FBWP_SR_WIP     0
`define FBWP_SR_WEL     1
`define FBWP_SR_BP_LO   2
`define FBWP_SR_BP_HI   5
`define FBWP_SR_QE      6
`define FBWP_SR_SWD     7
// non-volatile reset value of status cells
`define FBWP_NV_RESET   6'h00
// block geometry
`define FBWP_BLK_LSB    16
`define FBWP_HALF_LSB   15
`define FBWP_ADDR_W     24
// operation timing, in clock cycles
`define FBWP_BUSY_CYC   8'h08
`endif

// >>> pkg/fbwp_pkg.sv
package fbwp_pkg;
  typedef enum logic [2:0] {
    FBWP_D4M   = 3'h0,
    FBWP_D2M   = 3'h1,
    FBWP_D1M   = 3'h2,
    FBWP_D512K = 3'h3,
    FBWP_D256K = 3'h4
  } fbwp_density_e;

  typedef enum logic [3:0] {
    FBWP_OP_PROG   = 4'h1,
    FBWP_OP_ERASE  = 4'h2,
    FBWP_OP_CHIP   = 4'h4,
    FBWP_OP_STATUS = 4'h8
  } fbwp_op_e;

  typedef enum logic [2:0] {
    FBWP_IDLE = 3'b001,
    FBWP_BUSY = 3'b010,
    FBWP_DONE = 3'b100
  } fbwp_state_e;
endpackage

// >>> hdl/fbwp_range_decode.sv
`timescale 1ns/100ps
`include "fbwp_params.svh"
module fbwp_range_decode
  import fbwp_pkg::*;
(
  input  wire logic [3:0]    protect_code,
  input  wire fbwp_density_e density,
  output logic      [2:0]    lo_blk,
  output logic      [2:0]    hi_blk,
  output logic               any_prot
);
  logic [3:0] c;
  assign c = protect_code;

  always_comb begin
    lo_blk   = 3'h0;
    hi_blk   = 3'h0;
    any_prot = (c != 4'h0);
    unique case (density)
      FBWP_D4M: begin
        hi_blk = 3'h7;
        unique case (c)
          4'h1: lo_blk = 3'h7;
          4'h2: lo_blk = 3'h6;
          4'h3: lo_blk = 3'h4;
          4'h4: lo_blk = 3'h2;
          4'h5: lo_blk = 3'h1;
          4'h9: hi_blk = 3'h0;
          4'ha: hi_blk = 3'h1;
          4'hb: hi_blk = 3'h3;
          4'hc: hi_blk = 3'h5;
          4'hd: hi_blk = 3'h6;
          default: lo_blk = 3'h0;
        endcase
      end
      FBWP_D2M: begin
        hi_blk = 3'h3;
        unique case (c)
          4'h1: lo_blk = 3'h3;
          4'h2: lo_blk = 3'h2;
          4'h3: lo_blk = 3'h1;
          4'h9: hi_blk = 3'h0;
          4'ha: hi_blk = 3'h1;
          4'hb: hi_blk = 3'h2;
          default: lo_blk = 3'h0;
        endcase
      end
      FBWP_D1M: begin
        hi_blk = 3'h1;
        if (c == 4'h1) begin
          lo_blk = 3'h1;
        end else if (c == 4'h9) begin
          hi_blk = 3'h0;
        end
      end
      default: begin
        // single block: any nonzero code covers all of it
        hi_blk = 3'h0;
      end
    endcase
  end
endmodule

// >>> hdl/fbwp_core.sv
`timescale 1ns/100ps
`include "fbwp_params.svh"
// Functional notes
// - Decode the four protect-code bits into a region and refuse program or erase into it.
// - At 4Mb codes 0001-0101 protect the top 1,2,4,6,7 blocks ending at block 7.
// - At 4Mb codes 0110,0111,1000,1110,1111 protect all eight blocks.
// - At 4Mb codes 1001-1101 protect the bottom 1,2,4,6,7 blocks from block 0.
// - At 2Mb codes 0001-0011 top 1-3, 1001-1011 bottom 1-3, the rest all four blocks.
// - At 1Mb 0001 protects block 1, 1001 block 0, others both; smaller parts any nonzero all.
// - With status-write-disable clear the status byte is writable whatever the pin.
// - With it set, quad-enable clear and the pin low the status write command is ignored.
// - With it set and the pin high the status write command still updates the byte.
// - Quad-enable clear gives the two extra pins protect and pause functions.
// - Quad-enable set makes them data lines two and three.
// - The 1Mb variant with half_block_only set erases 32KB under the big block-erase opcode only.
// - Write commands need the write latch set first, else they are ignored.
// - Protect, quad and disable cells change only by the status write command.
module fbwp_core
  import fbwp_pkg::*;
#(
  parameter int ADDR_W = `FBWP_ADDR_W
)(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire fbwp_density_e     density,
  input  wire logic              half_block_only,
  input  wire logic              cmd_valid,
  input  wire fbwp_op_e          cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic              cmd_big_erase,
  input  wire logic [7:0]        cmd_status,
  input  wire logic              write_unlock_command,
  input  wire logic              write_lock_command,
  input  wire logic              write_protect_pin_n,
  input  wire logic              pause_pin_n,
  input  wire logic              data_line_two_in,
  input  wire logic              data_line_three_in,
  input  wire logic              quad_drive,
  input  wire logic              data_line_two_out_d,
  input  wire logic              data_line_three_out_d,
  output logic [7:0]             status_byte,
  output logic                   cmd_accept,
  output logic                   cmd_reject,
  output logic                   array_write,
  output logic [ADDR_W-1:0]      array_addr,
  output logic [ADDR_W-1:0]      array_span,
  output logic                   hw_protect_level,
  output logic                   pause_active,
  output logic                   quad_in2,
  output logic                   quad_in3,
  output logic                   data_line_two_out,
  output logic                   data_line_two_oe,
  output logic                   data_line_three_out,
  output logic                   data_line_three_oe
);
  // refuse widths that cannot hold the block index of the largest part
  if (ADDR_W < 19) begin : g_addr_chk
    $error("address width too small for 4Mb");
  end

  logic [5:0]        nv;
  logic              write_latch_flag;
  logic              busy;
  logic [7:0]        busy_cnt;
  fbwp_state_e       state;
  fbwp_state_e       next_state;
  logic [2:0]        lo_blk;
  logic [2:0]        hi_blk;
  logic              any_prot;
  logic [3:0]        protect_code;
  logic              quad_enable;
  logic              status_write_disable;

  assign protect_code         = nv[3:0];
  assign quad_enable          = nv[4];
  assign status_write_disable = nv[5];

  fbwp_range_decode u_dec (
    .protect_code (protect_code),
    .density      (density),
    .lo_blk       (lo_blk),
    .hi_blk       (hi_blk),
    .any_prot     (any_prot)
  );

  // pin muxing follows quad-enable
  wire wp_fn = ~quad_enable;
  assign hw_protect_level = wp_fn ? write_protect_pin_n : 1'b1;
  assign pause_active     = wp_fn & ~pause_pin_n;
  assign quad_in2         = quad_enable & data_line_two_in;
  assign quad_in3         = quad_enable & data_line_three_in;
  assign data_line_two_out   = data_line_two_out_d;
  assign data_line_three_out = data_line_three_out_d;
  assign data_line_two_oe    = quad_enable & quad_drive;
  assign data_line_three_oe  = quad_enable & quad_drive;

  // block range of the target
  wire [2:0] tgt_blk = cmd_addr[`FBWP_BLK_LSB+2:`FBWP_BLK_LSB];
  wire in_rng = any_prot && tgt_blk >= lo_blk && tgt_blk <= hi_blk;
  // whole chip is hit by any protection
  wire chip_hit = any_prot;
  // 1Mb variant: big erase shrinks to 32KB
  wire erase32 = half_block_only && density == FBWP_D1M;

  wire is_prog   = cmd_op == FBWP_OP_PROG;
  wire is_erase  = cmd_op == FBWP_OP_ERASE;
  wire is_chip   = cmd_op == FBWP_OP_CHIP;
  wire is_status = cmd_op == FBWP_OP_STATUS;

  wire hw_locked = status_write_disable & ~hw_protect_level;
  wire prot_fail = ((is_prog | is_erase) & in_rng)
                 | (is_chip & chip_hit);
  wire can_go = cmd_valid && state == FBWP_IDLE && write_latch_flag;
  wire go     = can_go && !prot_fail && !(is_status && hw_locked);
  assign cmd_accept = go;
  assign cmd_reject = cmd_valid && state == FBWP_IDLE && !go;

  wire [ADDR_W-1:0] span64 = ADDR_W'(1) << `FBWP_BLK_LSB;
  wire [ADDR_W-1:0] span32 = ADDR_W'(1) << `FBWP_HALF_LSB;
  wire [ADDR_W-1:0] next_span =
    (is_erase && cmd_big_erase && !erase32) ? span64 :
    (is_erase && cmd_big_erase) ? span32 : ADDR_W'(0);

  always_comb begin
    next_state = state;
    unique case (state)
      FBWP_IDLE: if (go) next_state = FBWP_BUSY;
      FBWP_BUSY: if (busy_cnt == 8'h00) next_state = FBWP_DONE;
      FBWP_DONE: next_state = FBWP_IDLE;
      default:   next_state = FBWP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= FBWP_IDLE;
      busy_cnt <= 8'h00;
    end else if (clk_en) begin
      state    <= next_state;
      busy_cnt <= go ? `FBWP_BUSY_CYC - 8'h01
                : (busy_cnt != 8'h00 ? busy_cnt - 8'h01 : 8'h00);
    end
  end
  assign busy = state != FBWP_IDLE;

  // non-volatile cells: only the status write touches them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nv <= `FBWP_NV_RESET;
    end else if (clk_en && go && is_status) begin
      nv <= cmd_status[`FBWP_SR_SWD:`FBWP_SR_BP_LO];
    end
  end

  // latch clears when an operation completes; unlock wins over lock but is ignored while busy, done included
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_latch_flag <= 1'b0;
    end else if (clk_en) begin
      if (write_unlock_command && !busy) begin
        write_latch_flag <= 1'b1;
      end else if (write_lock_command || state == FBWP_DONE) begin
        write_latch_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      array_write <= 1'b0;
      array_addr  <= '0;
      array_span  <= '0;
    end else if (clk_en) begin
      array_write <= go && !is_status;
      if (go) begin
        array_addr <= cmd_addr;
        array_span <= next_span;
      end
    end
  end

  assign status_byte = {nv, write_latch_flag, busy};

  no_prot_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && cmd_valid && prot_fail |-> !cmd_accept)
    else $error("protected target accepted");
  top4_a: assert property (@(posedge clk) disable iff (!arst_n)
    density == FBWP_D4M && protect_code == 4'h3 |-> lo_blk == 3'h4 && hi_blk == 3'h7)
    else $error("4Mb top range wrong");
  all4_a: assert property (@(posedge clk) disable iff (!arst_n)
    density == FBWP_D4M && protect_code == 4'h7 |-> lo_blk == 3'h0 && hi_blk == 3'h7)
    else $error("4Mb all range wrong");
  bot4_a: assert property (@(posedge clk) disable iff (!arst_n)
    density == FBWP_D4M && protect_code == 4'hc |-> lo_blk == 3'h0 && hi_blk == 3'h5)
    else $error("4Mb bottom range wrong");
  two_meg_a: assert property (@(posedge clk) disable iff (!arst_n)
    density == FBWP_D2M && protect_code == 4'h3 |-> lo_blk == 3'h1 && hi_blk == 3'h3)
    else $error("2Mb range wrong");
  one_meg_a: assert property (@(posedge clk) disable iff (!arst_n)
    density == FBWP_D1M && protect_code == 4'h9 |-> any_prot && hi_blk == 3'h0)
    else $error("1Mb range wrong");
  status_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && status_write_disable && !write_protect_pin_n && !quad_enable
    |=> $stable(nv))
    else $error("locked status changed");
  status_open_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && go && is_status |=> nv == $past(cmd_status[7:2]))
    else $error("status write lost");
  quad_pins_a: assert property (@(posedge clk) disable iff (!arst_n)
    !quad_enable |-> !data_line_two_oe && !data_line_three_oe)
    else $error("quad pins driven");
  latch_need_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_accept |-> write_latch_flag)
    else $error("accept without latch");
  latch_done_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && go |-> ##[1:20] !write_latch_flag || write_unlock_command)
    else $error("latch not cleared");
endmodule

// >>> bench/fbwp_host_model.sv
`timescale 1ns/100ps
module fbwp_host_model
  import fbwp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] status_byte,
  input  wire logic       cmd_accept,
  input  wire logic       cmd_reject,
  output fbwp_op_e        cmd_op,
  output logic            cmd_valid,
  output logic [23:0]     cmd_addr,
  output logic            cmd_big_erase,
  output logic [7:0]      cmd_status,
  output logic            write_unlock_command,
  output logic            write_lock_command
);
  initial begin
    {cmd_valid, cmd_addr, cmd_big_erase, cmd_status} = '0;
    {write_unlock_command, write_lock_command} = 2'b00;
    cmd_op = FBWP_OP_PROG;
  end

  task automatic send(input fbwp_op_e op, input logic [23:0] a,
                      input logic big, input logic [7:0] st, input bit unl,
                      output logic acc, output logic rej, output bit hang);
    @(posedge clk);
    write_unlock_command <= unl;
    write_lock_command   <= !unl;
    @(posedge clk);
    write_unlock_command <= 1'b0;
    write_lock_command   <= 1'b0;
    cmd_valid     <= 1'b1;
    cmd_op        <= op;
    cmd_addr      <= a;
    cmd_big_erase <= big;
    cmd_status    <= st;
    @(negedge clk);
    acc = cmd_accept;
    rej = cmd_reject;
    @(posedge clk);
    cmd_valid  <= 1'b0;
    // released lines must not keep the old value
    cmd_addr   <= ~a;
    cmd_status <= ~st;
    hang = 1'b0;
    if (acc === 1'b1) begin
      hang = 1'b1;
      for (int i = 0; i < 40 && hang; i++) begin
        @(negedge clk);
        if (status_byte[0] === 1'b0)
          hang = 1'b0;
      end
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import fbwp_pkg::*;
;
  logic          clk, arst_n, clk_en, half, wp_pin_n, pause_pin_n;
  logic          d2_in, d3_in, quad_drive, d2_d, d3_d, cmd_valid, big_e;
  logic          unl_c, lock_c, cmd_accept, cmd_reject, array_write, hw_lvl;
  logic          pause_active, quad_in2, quad_in3, d2_out, d2_oe, d3_out, d3_oe;
  logic [23:0]   cmd_addr, array_addr, array_span;
  logic [7:0]    cmd_status, status_byte;
  fbwp_density_e density;
  fbwp_op_e      cmd_op;
  int            errors, n_checks;

  fbwp_core u_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .density(density), .half_block_only(half), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_big_erase(big_e),
    .cmd_status(cmd_status), .write_unlock_command(unl_c),
    .write_lock_command(lock_c), .write_protect_pin_n(wp_pin_n),
    .pause_pin_n(pause_pin_n), .data_line_two_in(d2_in),
    .data_line_three_in(d3_in), .quad_drive(quad_drive),
    .data_line_two_out_d(d2_d), .data_line_three_out_d(d3_d),
    .status_byte(status_byte), .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject), .array_write(array_write),
    .array_addr(array_addr), .array_span(array_span),
    .hw_protect_level(hw_lvl), .pause_active(pause_active),
    .quad_in2(quad_in2), .quad_in3(quad_in3), .data_line_two_out(d2_out),
    .data_line_two_oe(d2_oe), .data_line_three_out(d3_out),
    .data_line_three_oe(d3_oe));

  fbwp_host_model u_host (.clk(clk), .status_byte(status_byte),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .cmd_op(cmd_op),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_big_erase(big_e),
    .cmd_status(cmd_status), .write_unlock_command(unl_c),
    .write_lock_command(lock_c));

  task automatic end_sim;
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // reference table, kept apart from the design's decoder
  function automatic bit prot(int d, int c, int b);
    int tbl[6] = '{0, 1, 2, 4, 6, 7};
    int n, lim, k;
    n = (d > 3) ? 1 : 8 >> d;
    lim = (d == 0) ? 5 : (d == 1) ? 3 : (d == 2) ? 1 : 0;
    k = c % 8;
    if (c == 0)
      return 1'b0;
    if (k == 0 || k > lim)
      return 1'b1;
    if (d == 0)
      k = tbl[k];
    return (c < 8) ? (b >= n - k) : (b < k);
  endfunction

  task automatic op(fbwp_op_e o, logic [23:0] a, logic big, logic [7:0] st,
                    bit unl, bit exp);
    logic acc, rej;
    bit   hang;
    u_host.send(o, a, big, st, unl, acc, rej, hang);
    chk(acc === exp && rej === !exp, "accept or reject wrong");
    if (hang) begin
      errors++;
      $display("MISMATCH %0t busy never ended", $time);
      end_sim();
    end
    if (exp)
      chk(status_byte[1] === 1'b0, "latch not cleared");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("MISMATCH %0t run limit reached", $time);
    end_sim();
  end

  initial begin
    int unsigned seed;
    int          b;
    logic [23:0] a;
    fbwp_op_e    o;
    {arst_n, half, wp_pin_n, d2_in, quad_drive, d2_d, d3_d} = '0;
    {clk_en, pause_pin_n, d3_in} = 3'b111;
    density = FBWP_D4M;
    errors = 0;
    n_checks = 0;
    seed = $urandom(32'hdc34);
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int d = 0; d < 5; d++) begin
      for (int c = 0; c < 16; c++) begin
        density <= fbwp_density_e'(d);
        b = $urandom % ((d > 3) ? 1 : 8 >> d);
        a = {5'h00, b[2:0], 16'($urandom)};
        a[15] = (d == 4) ? 1'b0 : a[15];
        o = ($urandom % 2) ? FBWP_OP_ERASE : FBWP_OP_PROG;
        op(FBWP_OP_STATUS, 24'h0, 1'b0, {2'b00, c[3:0], 2'b00}, 1, 1);
        chk(status_byte[7:2] === {2'b00, c[3:0]}, "code not stored");
        op(o, a, 1'($urandom), 8'h00, 1, !prot(d, c, b));
        if (o == FBWP_OP_PROG && !prot(d, c, b))
          chk(array_addr === a, "array address");
        chk(status_byte[7:2] === {2'b00, c[3:0]}, "cells moved");
        op(FBWP_OP_CHIP, a, 1'b0, 8'h00, 1, c == 0);
      end
    end
    density <= FBWP_D4M;
    op(FBWP_OP_STATUS, 24'h0, 1'b0, 8'h00, 1, 1);
    op(FBWP_OP_PROG, 24'h010000, 1'b0, 8'h00, 0, 0);
    op(FBWP_OP_STATUS, 24'h0, 1'b0, 8'h80, 1, 1);
    op(FBWP_OP_STATUS, 24'h0, 1'b0, 8'h84, 1, 0);
    chk(status_byte[7:2] === 6'h20, "locked byte changed");
    wp_pin_n <= 1'b1;
    op(FBWP_OP_STATUS, 24'h0, 1'b0, 8'h04, 1, 1);
    chk(status_byte[7:2] === 6'h01, "byte not updated");
    // pins are driven, never tied to a rail, so quad may be set
    pause_pin_n <= 1'b0;
    quad_drive  <= 1'b1;
    d2_d        <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(pause_active === 1'b1 && d2_oe === 1'b0 && d3_oe === 1'b0, "pins");
    pause_pin_n <= 1'b1;
    op(FBWP_OP_STATUS, 24'h0, 1'b0, 8'h40, 1, 1);
    pause_pin_n <= 1'b0;
    d2_in       <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(pause_active === 1'b0 && d2_oe === 1'b1 && d2_out === 1'b1 &&
        d3_oe === 1'b1 && d3_out === 1'b0 && quad_in2 === 1'b1 &&
        quad_in3 === 1'b1, "quad lines");
    pause_pin_n <= 1'b1;
    quad_drive  <= 1'b0;
    op(FBWP_OP_STATUS, 24'h0, 1'b0, 8'h04, 1, 1);
    density <= FBWP_D1M;
    half    <= 1'b1;
    op(FBWP_OP_ERASE, 24'h000000, 1'b1, 8'h00, 1, 1);
    chk(array_span === 24'h008000, "half block span");
    op(FBWP_OP_ERASE, 24'h010000, 1'b1, 8'h00, 1, 0);
    end_sim();
  end
endmodule
